// ### common/dah_pkg.sv
package dah_pkg;

  // ***************************************************************
  // apb register map
  // ***************************************************************
  localparam logic [7:0]  ADDR_CFG     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_CTRL    = 8'h08;
  localparam int          CTRL_CLOSE   = 0;

  // ***************************************************************
  // mode register: {ecas[3:0], bank[1:0], col[10:0], row[10:0]}
  // ***************************************************************
  localparam int          ROW_W        = 11;
  localparam int          COL_W        = 11;
  localparam int          BANK_W       = 2;
  localparam int          ECAS_W       = 4;
  localparam int          MODE_W       = 28;
  localparam logic [27:0] MODE_RST     = 28'h0000000;
  localparam int          POS_ACC_MODE = 0;
  localparam int          POS_TERM_LO  = 1;
  localparam int          POS_NIBBLE   = 3;
  localparam int          POS_ACK_FALL = 4;
  localparam int          POS_WAIT_MODE = 6;
  localparam int          POS_ACK_CNT  = 11;
  localparam int          STATUS_W     = 12;

  // termination modes held in the mode register
  localparam logic [1:0]  TERM_SINGLE  = 2'h0;
  localparam logic [1:0]  TERM_PAGE    = 2'h1;
  localparam logic [1:0]  TERM_CACHE   = 2'h2;
  localparam logic [1:0]  TERM_INHIBIT = 2'h3;

  // ***************************************************************
  // timing and burst
  // ***************************************************************
  localparam logic [2:0]  ACK_CNT_MIN  = 3'h1;
  localparam logic [1:0]  BURST_LAST   = 2'h3;

  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_PRECH = 7'b0000010,
    S_WAITQ = 7'b0000100,
    S_COUNT = 7'b0001000,
    S_ACK   = 7'b0010000,
    S_HOLD  = 7'b0100000,
    S_SPARE = 7'b1000000
  } dah_state_t;

  typedef struct packed {
    dah_state_t  st;
    logic [2:0]  cnt;
    logic        wait_used;
    logic [1:0]  beat;
    logic [10:0] row;
    logic [10:0] col;
    logic [1:0]  bank;
    logic        page_open;
    logic [10:0] open_row;
    logic [1:0]  open_bank;
    logic        ras_n;
    logic        cas_n;
    logic        ack_n;
    logic        grant_n;
  } dah_core_t;

  typedef struct packed {
    logic [27:0] mode;
    logic        close_page;
    logic [31:0] prdata;
    logic        pslverr;
  } dah_regs_t;

endpackage

// ### common/dah_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dah_cfg_if;
  logic [27:0] mode;
  logic        close_page;
  logic        busy;
  logic [11:0] status;

  modport regs (
    output mode,
    output close_page,
    input  busy,
    input  status
  );

  modport core (
    input  mode,
    input  close_page,
    output busy,
    output status
  );
endinterface
`default_nettype wire

// ### core/dah_regs.sv
`timescale 1ns/1ps
`default_nettype none
module dah_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        mode_load_strobe,
  input  wire logic [10:0] row_in,
  input  wire logic [10:0] col_in,
  input  wire logic [1:0]  bank_in,
  input  wire logic [3:0]  ecas_in,
  dah_cfg_if.regs          cfg
);

  dah_pkg::dah_regs_t r;
  dah_pkg::dah_regs_t next_r;
  logic               setup;
  logic               wr;
  logic               hit;

  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite;
  assign hit   = (paddr == dah_pkg::ADDR_CFG) ||
                 (paddr == dah_pkg::ADDR_STATUS) ||
                 (paddr == dah_pkg::ADDR_CTRL);

  always_comb begin
    next_r            = r;
    next_r.close_page = 1'b0;
    // read data and error are fixed at the setup edge
    if (setup) begin
      next_r.pslverr = !hit || (pwrite && paddr == dah_pkg::ADDR_CFG
                                && cfg.busy);
      next_r.prdata  = 32'h00000000;
      if (!pwrite && paddr == dah_pkg::ADDR_CFG) begin
        next_r.prdata[27:0] = r.mode;
      end else if (!pwrite && paddr == dah_pkg::ADDR_STATUS) begin
        next_r.prdata[11:0] = cfg.status;
      end
    end
    if (wr && paddr == dah_pkg::ADDR_CFG && !cfg.busy) begin
      next_r.mode = pwdata[27:0];
    end
    if (wr && paddr == dah_pkg::ADDR_CTRL) begin
      next_r.close_page = pwdata[dah_pkg::CTRL_CLOSE];
    end
    if (mode_load_strobe && !cfg.busy) begin
      next_r.mode = {ecas_in, bank_in, col_in, row_in};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{mode: dah_pkg::MODE_RST, close_page: 1'b0,
             prdata: 32'h00000000, pslverr: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign prdata         = r.prdata;
  assign pslverr        = r.pslverr;
  assign cfg.mode       = r.mode;
  assign cfg.close_page = r.close_page;

endmodule
`default_nettype wire

// ### core/dah_access.sv
// What this block does
// - address strobe latches row, column, bank and starts an access
// - access mode 0 is latch enable, mode 1 is address strobe
// - access starts only with chip select active
// - single mode: request removal raises ras and cas
// - page mode with page dram: request removal raises only cas, ras held; with nibble dram ras rises too
// - burst inhibit mode samples termination at ack-negating edge
// - burst inhibit stops the device from continuing the burst
// - inhibit ends nibble with ras and cas, page with cas only
// - ack ends processor access; in single and page modes held until request removal
// - burst modes negate ack one edge after asserting it
// - wait mode 0: wait insert sampled once at ack point
// - wait seen in mode 0 adds one edge, no resample
// - wait mode 1: sample at start, defer count if active
// - wait mode 1: resample each edge, then count and stop
// - grant follows access ras, delayed for deferred accesses
// - mode load strobe captures address pins into mode register
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dah_access (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        address_strobe,
  input  wire logic        chip_select_n,
  input  wire logic        access_request_n,
  input  wire logic        wait_insert_n,
  input  wire logic        mode_load_strobe,
  input  wire logic [10:0] row_in,
  input  wire logic [10:0] col_in,
  input  wire logic [1:0]  bank_in,
  input  wire logic [3:0]  ecas_in,
  output logic             transfer_ack_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             grant_n,
  output logic      [10:0] row_addr,
  output logic      [10:0] col_addr,
  output logic      [1:0]  bank_sel
);

  // ***************************************************************
  // register file
  // ***************************************************************
  dah_cfg_if cfg ();

  dah_regs u_regs (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pslverr          (pslverr),
    .mode_load_strobe (mode_load_strobe),
    .row_in           (row_in),
    .col_in           (col_in),
    .bank_in          (bank_in),
    .ecas_in          (ecas_in),
    .cfg              (cfg.regs)
  );

  // zero-wait slave: access phase always completes
  assign pready = 1'b1;

  // ***************************************************************
  // mode fields
  // ***************************************************************
  logic       acc_strobe_mode;
  logic [1:0] term_mode;
  logic       nibble_dram;
  logic       ack_falling;
  logic       wait_mode_bit;
  logic [2:0] ack_count;
  logic [2:0] ack_load;
  logic       burst_mode;
  logic       page_like;

  assign acc_strobe_mode = cfg.mode[dah_pkg::POS_ACC_MODE];
  assign term_mode       = cfg.mode[dah_pkg::POS_TERM_LO +: 2];
  assign nibble_dram     = cfg.mode[dah_pkg::POS_NIBBLE];
  assign ack_falling     = cfg.mode[dah_pkg::POS_ACK_FALL];
  assign wait_mode_bit   = cfg.mode[dah_pkg::POS_WAIT_MODE];
  assign ack_count       = cfg.mode[dah_pkg::POS_ACK_CNT +: 3];
  assign ack_load        = (ack_count < dah_pkg::ACK_CNT_MIN) ?
                           dah_pkg::ACK_CNT_MIN : ack_count;
  assign burst_mode      = term_mode[1];
  assign page_like       = !nibble_dram;

  // ***************************************************************
  // pin qualifiers
  // ***************************************************************
  logic strobe_active;
  logic start_req;
  logic wait_active;
  logic request_held;
  logic burst_go_on;
  logic page_hit;

  // latch enable is high-true, address strobe low-true
  assign strobe_active = acc_strobe_mode ? !address_strobe : address_strobe;
  assign start_req     = strobe_active && !chip_select_n;
  assign wait_active   = !wait_insert_n;
  assign request_held  = !access_request_n;

  // ***************************************************************
  // access state
  // ***************************************************************
  dah_pkg::dah_core_t s;
  dah_pkg::dah_core_t next_s;

  assign page_hit = s.page_open && (row_in == s.open_row) &&
                    (bank_in == s.open_bank);

  // termination pin read as cache request or burst inhibit
  always_comb begin
    if (term_mode == dah_pkg::TERM_CACHE) begin
      burst_go_on = request_held && (s.beat != dah_pkg::BURST_LAST);
    end else begin
      burst_go_on = !request_held && (s.beat != dah_pkg::BURST_LAST);
    end
  end

  always_comb begin
    next_s = s;

    // latch enable is transparent while idle and high
    if (s.st == dah_pkg::S_IDLE && !acc_strobe_mode && address_strobe) begin
      next_s.row  = row_in;
      next_s.col  = col_in;
      next_s.bank = bank_in;
    end

    case (s.st)
      dah_pkg::S_IDLE: begin
        if (cfg.close_page && s.page_open) begin
          next_s.page_open = 1'b0;
          next_s.ras_n     = 1'b1;
          next_s.grant_n   = 1'b1;
        end else if (start_req) begin
          // capture addresses and begin the access
          next_s.row       = row_in;
          next_s.col       = col_in;
          next_s.bank      = bank_in;
          next_s.beat      = 2'h0;
          next_s.wait_used = 1'b0;
          next_s.cnt       = ack_load;
          if (s.page_open && !page_hit) begin
            // page miss defers ras and grant
            next_s.ras_n     = 1'b1;
            next_s.grant_n   = 1'b1;
            next_s.page_open = 1'b0;
            next_s.st        = dah_pkg::S_PRECH;
          end else begin
            next_s.ras_n     = 1'b0;
            next_s.grant_n   = 1'b0;
            next_s.page_open = 1'b0;
            if (wait_mode_bit && wait_active) begin
              next_s.st = dah_pkg::S_WAITQ;
            end else begin
              next_s.wait_used = wait_mode_bit;
              next_s.st        = dah_pkg::S_COUNT;
            end
          end
        end
      end

      dah_pkg::S_PRECH: begin
        // one precharge cycle, then ras for the deferred access
        next_s.ras_n   = 1'b0;
        next_s.grant_n = 1'b0;
        next_s.cnt     = ack_load;
        if (wait_mode_bit && wait_active) begin
          next_s.st = dah_pkg::S_WAITQ;
        end else begin
          next_s.wait_used = wait_mode_bit;
          next_s.st        = dah_pkg::S_COUNT;
        end
      end

      dah_pkg::S_WAITQ: begin
        next_s.cas_n = 1'b0;
        // resample until negated, then stop sampling
        if (!wait_active) begin
          next_s.cnt       = ack_load;
          next_s.wait_used = 1'b1;
          next_s.st        = dah_pkg::S_COUNT;
        end
      end

      dah_pkg::S_COUNT: begin
        next_s.cas_n = 1'b0;
        if (s.cnt <= dah_pkg::ACK_CNT_MIN) begin
          // single sample at the ack point
          if (!s.wait_used && wait_active) begin
            next_s.wait_used = 1'b1;
          end else begin
            // assert ack to end the cpu access
            next_s.ack_n = 1'b0;
            next_s.st    = dah_pkg::S_ACK;
          end
        end else begin
          next_s.cnt = s.cnt - 3'h1;
        end
      end

      dah_pkg::S_ACK: begin
        if (burst_mode) begin
          next_s.ack_n = 1'b1;
          if (burst_go_on) begin
            next_s.beat      = s.beat + 2'h1;
            next_s.cnt       = ack_load;
            next_s.wait_used = 1'b1;
            next_s.st        = dah_pkg::S_COUNT;
          end else begin
            // nibble closes row, page keeps it
            next_s.cas_n = 1'b1;
            next_s.st    = dah_pkg::S_IDLE;
            if (nibble_dram) begin
              next_s.ras_n   = 1'b1;
              next_s.grant_n = 1'b1;
            end else begin
              next_s.page_open = 1'b1;
              next_s.open_row  = s.row;
              next_s.open_bank = s.bank;
            end
          end
        end else begin
          next_s.st = dah_pkg::S_HOLD;
          if (!request_held) begin
            next_s.st = dah_pkg::S_HOLD;
          end
        end
      end

      dah_pkg::S_HOLD: begin
        // ack stays until the request goes away
        if (!request_held) begin
          next_s.ack_n = 1'b1;
          next_s.cas_n = 1'b1;
          next_s.st    = dah_pkg::S_IDLE;
          if (term_mode == dah_pkg::TERM_PAGE && page_like) begin
            // only cas rises, row stays open
            next_s.page_open = 1'b1;
            next_s.open_row  = s.row;
            next_s.open_bank = s.bank;
          end else begin
            next_s.ras_n   = 1'b1;
            next_s.grant_n = 1'b1;
          end
        end
      end

      default: begin
        next_s.st      = dah_pkg::S_IDLE;
        next_s.ras_n   = 1'b1;
        next_s.cas_n   = 1'b1;
        next_s.ack_n   = 1'b1;
        next_s.grant_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{st: dah_pkg::S_IDLE, cnt: 3'h0, wait_used: 1'b0,
             beat: 2'h0, row: 11'h000, col: 11'h000, bank: 2'h0,
             page_open: 1'b0, open_row: 11'h000, open_bank: 2'h0,
             ras_n: 1'b1, cas_n: 1'b1, ack_n: 1'b1, grant_n: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  // ***************************************************************
  // outputs and status
  // ***************************************************************
  // mode locked while an access or open page exists
  assign cfg.busy   = (s.st != dah_pkg::S_IDLE) || s.page_open;
  assign cfg.status = {s.page_open, s.grant_n, s.cas_n, s.ras_n,
                       s.ack_n, s.st};

  assign transfer_ack_n = s.ack_n;
  assign ras_n          = s.ras_n;
  assign cas_n          = s.cas_n;
  assign grant_n        = s.grant_n;
  assign row_addr       = s.row;
  assign col_addr       = s.col;
  assign bank_sel       = s.bank;

  // acknowledge edge select is kept in the mode word only; all timing
  // here runs on the rising edge of the single clock
  logic unused_cfg;
  assign unused_cfg = ack_falling;

endmodule
`default_nettype wire

// ### tb/dah_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module dah_cpu_model (
  input  wire logic pclk,
  input  wire logic transfer_ack_n,
  output logic      address_strobe,
  output logic      chip_select_n,
  output logic      access_request_n,
  output logic      wait_insert_n
);
  initial begin
    address_strobe   = 1'b0;
    chip_select_n    = 1'b1;
    access_request_n = 1'b1;
    wait_insert_n    = 1'b1;
  end
  // ***************************************************************
  // one processor access
  // ***************************************************************
  // strobe and select opening cycle
  task automatic access(input logic am, input logic cs, input logic rq,
                        input int wt, input int hold, output int lat);
    lat = 0;
    @(posedge pclk);
    address_strobe   <= ~am;
    chip_select_n    <= ~cs;
    access_request_n <= rq;
    wait_insert_n    <= (wt == 0);
    @(posedge pclk);
    address_strobe <= am;
    chip_select_n  <= 1'b1;
    @(negedge pclk);
    while (transfer_ack_n !== 1'b0 && lat < 40) begin
      @(posedge pclk);
      lat++;
      if (lat >= wt) wait_insert_n <= 1'b1;
      @(negedge pclk);
    end
    repeat (hold) @(posedge pclk);
    @(posedge pclk);
    access_request_n <= 1'b1;
    wait_insert_n    <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### tb/dah_access_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dah_access_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        chip_select_n,
  input wire logic        access_request_n,
  input wire logic        transfer_ack_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        grant_n,
  input wire logic [10:0] row_addr,
  input wire logic [1:0]  bank_sel
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ***************************************************************
  // access strobes
  // ***************************************************************
  no_select_a: assert property (
    ras_n && $past(ras_n) && chip_select_n && $past(chip_select_n)
    |=> ras_n) else $error("ras fell without chip select");
  grant_ras_a: assert property (!grant_n |-> !ras_n)
    else $error("grant low without ras");
  grant_drop_a: assert property ($rose(ras_n) |-> grant_n)
    else $error("grant held after ras rose");
  cas_ras_a: assert property (!cas_n |-> !ras_n)
    else $error("cas low without ras");
  cas_late_a: assert property ($fell(ras_n) |-> cas_n)
    else $error("cas fell with ras");
  row_hold_a: assert property (
    !ras_n && $past(!ras_n) |-> $stable(row_addr) && $stable(bank_sel))
    else $error("row address moved under ras");
  // ***************************************************************
  // acknowledge
  // ***************************************************************
  ack_ras_a: assert property (!transfer_ack_n |-> !ras_n)
    else $error("ack low without ras");
  ack_after_a: assert property ($fell(transfer_ack_n) |-> !$past(ras_n))
    else $error("ack fell with ras");
  ack_release_a: assert property (
    !transfer_ack_n && access_request_n |=> transfer_ack_n)
    else $error("ack held after request removed");
  apb_err_a: assert property (
    psel && !penable && paddr > dah_pkg::ADDR_CTRL |=> pslverr && pready)
    else $error("unmapped access not refused");
  cover property ($fell(transfer_ack_n));
  cover property ($rose(ras_n) && $past(!transfer_ack_n));
  cover property (!ras_n && cas_n && transfer_ack_n);
endmodule
bind dah_access dah_access_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .chip_select_n(chip_select_n), .access_request_n(access_request_n),
  .transfer_ack_n(transfer_ack_n), .ras_n(ras_n), .cas_n(cas_n),
  .grant_n(grant_n), .row_addr(row_addr), .bank_sel(bank_sel)
);
`default_nettype wire

// ### tb/dram_access_handshake_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dram_access_handshake_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        address_strobe, chip_select_n, access_request_n;
  logic        wait_insert_n, mode_load_strobe;
  logic        transfer_ack_n, ras_n, cas_n, grant_n;
  logic [10:0] row_in, col_in, row_addr, col_addr;
  logic [1:0]  bank_in, bank_sel;
  logic [3:0]  ecas_in;
  int          n_fail = 0, checks_done = 0, n_ack = 0, cyc = 0;
  int          lat, n, k;
  dah_access u_dah_access (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .address_strobe(address_strobe),
    .chip_select_n(chip_select_n), .access_request_n(access_request_n),
    .wait_insert_n(wait_insert_n), .mode_load_strobe(mode_load_strobe),
    .row_in(row_in), .col_in(col_in), .bank_in(bank_in),
    .ecas_in(ecas_in), .transfer_ack_n(transfer_ack_n), .ras_n(ras_n),
    .cas_n(cas_n), .grant_n(grant_n), .row_addr(row_addr),
    .col_addr(col_addr), .bank_sel(bank_sel));
  dah_cpu_model u_dah_cpu_model (
    .pclk(pclk), .transfer_ack_n(transfer_ack_n),
    .address_strobe(address_strobe), .chip_select_n(chip_select_n),
    .access_request_n(access_request_n), .wait_insert_n(wait_insert_n));
  // ***************************************************************
  // clock, watchdog, helpers
  // ***************************************************************
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(negedge pclk) if (transfer_ack_n === 1'b0) n_ack++;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      $display("watchdog expired");
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] cfg(logic am, logic [1:0] tm, logic nb,
                                      logic wm, logic [2:0] c);
    cfg = 32'h0;
    cfg[dah_pkg::POS_ACC_MODE] = am;
    cfg[dah_pkg::POS_TERM_LO +: 2] = tm;
    cfg[dah_pkg::POS_NIBBLE] = nb;
    cfg[dah_pkg::POS_WAIT_MODE] = wm;
    cfg[dah_pkg::POS_ACK_CNT +: 3] = c;
  endfunction
  // edges after ras to ack: count, one fixed wait
  function automatic int lat_fix(logic [2:0] c, logic w);
    return ((c == 3'h0) ? 1 : int'(c)) + int'(w);
  endfunction
  function automatic logic [31:0] pins();
    return {29'h0, ras_n, cas_n, transfer_ack_n};
  endfunction
  task automatic settle();
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic close_chk(input string nm);
    apb(1'b1, dah_pkg::ADDR_CTRL, 32'h1 << dah_pkg::CTRL_CLOSE);
    settle();
    chk(nm, 32'h7, pins());
  endtask
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    void'($urandom(32'h50cdab7f));
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mode_load_strobe = 1'b0;
    {row_in, col_in, bank_in, ecas_in} = 28'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, dah_pkg::ADDR_CFG, 32'h0);
    chk("cfg reset", {4'h0, dah_pkg::MODE_RST}, rd);
    apb(1'b0, dah_pkg::ADDR_STATUS, 32'h0);
    chk("status reset", 32'h00000781, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    $display("test reset done");
    {row_in, col_in, bank_in, ecas_in} <= 28'($urandom);
    @(posedge pclk);
    mode_load_strobe <= 1'b1;
    @(posedge pclk);
    mode_load_strobe <= 1'b0;
    apb(1'b0, dah_pkg::ADDR_CFG, 32'h0);
    chk("mode load", {4'h0, ecas_in, bank_in, col_in, row_in}, rd);
    $display("test mode load done");
    for (int i = 0; i < 6; i++) begin
      n = $urandom_range(0, 7);
      k = $urandom_range(0, 1);
      apb(1'b1, dah_pkg::ADDR_CFG,
          cfg(i[0], dah_pkg::TERM_SINGLE, 1'b0, 1'b0, 3'(n)));
      row_in <= 11'($urandom);
      u_dah_cpu_model.access(i[0], 1'b1, 1'b0, k * 40, i, lat);
      chk("single lat", lat_fix(3'(n), k[0]), lat);
      chk("row latch", {21'h0, row_in}, {21'h0, row_addr});
      settle();
      chk("single end", 32'h7, pins());
    end
    u_dah_cpu_model.access(1'b1, 1'b0, 1'b0, 0, 0, lat);
    chk("no select", 32'd40, lat);
    $display("test single done");
    for (int i = 0; i < 3; i++) begin
      n = $urandom_range(1, 7);
      k = $urandom_range(2, 8);
      apb(1'b1, dah_pkg::ADDR_CFG,
          cfg(1'b0, dah_pkg::TERM_SINGLE, 1'b0, 1'b1, 3'(n)));
      u_dah_cpu_model.access(1'b0, 1'b1, 1'b0, k, 0, lat);
      chk("defer lat", 1, 32'((lat > k + n) && (lat <= k + n + 3)));
      settle();
      chk("defer end", 32'h7, pins());
    end
    $display("test indefinite wait done");
    apb(1'b1, dah_pkg::ADDR_CFG,
        cfg(1'b0, dah_pkg::TERM_PAGE, 1'b0, 1'b0, 3'h1));
    u_dah_cpu_model.access(1'b0, 1'b1, 1'b0, 0, 2, lat);
    settle();
    chk("page hold", 32'h3, pins());
    row_in <= ~row_addr;
    u_dah_cpu_model.access(1'b0, 1'b1, 1'b0, 0, 0, lat);
    chk("page miss lat", lat_fix(3'h1, 1'b0) + 1, lat);
    settle();
    chk("miss hold", 32'h3, pins());
    apb(1'b1, dah_pkg::ADDR_CFG, 32'h0);
    chk("busy write", 32'h1, {31'h0, er});
    close_chk("page close");
    $display("test page done");
    apb(1'b1, dah_pkg::ADDR_CFG,
        cfg(1'b0, dah_pkg::TERM_CACHE, 1'b1, 1'b0, 3'h1));
    n_ack = 0;
    u_dah_cpu_model.access(1'b0, 1'b1, 1'b0, 0, 30, lat);
    chk("cache beats", 32'(dah_pkg::BURST_LAST) + 1, n_ack);
    close_chk("cache end");
    for (int nb = 0; nb < 2; nb++) begin
      apb(1'b1, dah_pkg::ADDR_CFG,
          cfg(1'b0, dah_pkg::TERM_INHIBIT, nb[0], 1'b0, 3'h1));
      n_ack = 0;
      u_dah_cpu_model.access(1'b0, 1'b1, 1'b0, 0, 4, lat);
      @(negedge pclk);
      chk("inhibit beats", 32'h1, n_ack);
      chk("inhibit end", (nb == 1) ? 32'h7 : 32'h3, pins());
      close_chk("inhibit close");
    end
    apb(1'b1, dah_pkg::ADDR_CFG,
        cfg(1'b0, dah_pkg::TERM_INHIBIT, 1'b1, 1'b0, 3'h1));
    n_ack = 0;
    u_dah_cpu_model.access(1'b0, 1'b1, 1'b1, 0, 12, lat);
    chk("no inhibit beats", 32'(dah_pkg::BURST_LAST) + 1, n_ack);
    $display("test burst done");
    end_of_test();
  end
endmodule
`default_nettype wire
